// file: core/esf_pkg.sv
// Purpose: Shared constants and types of the encoder speed feedback block
// Assumes: 40 MHz system clock, 32-bit APB register bus
// Notes:   Setting ranges and reset values sit here once; logic uses names only
package esf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 25;
	localparam int unsigned TICK_PERIOD_NS   = 2_000_000;
	localparam int unsigned TICK_CYCLES      = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned GATE_MS          = 100;
	localparam int unsigned GATE_TICKS       = GATE_MS * 1_000_000 / TICK_PERIOD_NS;
	localparam int unsigned FAULT_UNIT_MS    = 100;
	localparam int unsigned FAULT_UNIT_TICKS = FAULT_UNIT_MS * 1_000_000 / TICK_PERIOD_NS;
	// Pulses per gate times this gives pulses per minute
	localparam int unsigned RPM_SCALE        = 60_000 / GATE_MS;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_PPR      = 8'h04;
	localparam logic [7:0] OFS_POLES    = 8'h08;
	localparam logic [7:0] OFS_KP       = 8'h0C;
	localparam logic [7:0] OFS_KI       = 8'h10;
	localparam logic [7:0] OFS_LIMIT    = 8'h14;
	localparam logic [7:0] OFS_DISP_INT = 8'h18;
	localparam logic [7:0] OFS_FILT_TC  = 8'h1C;
	localparam logic [7:0] OFS_FTIME    = 8'h20;
	localparam logic [7:0] OFS_REACT    = 8'h24;
	localparam logic [7:0] OFS_DISP_SEL = 8'h28;
	localparam logic [7:0] OFS_SPEED_REF= 8'h2C;
	localparam logic [7:0] OFS_RPM      = 8'h30;
	localparam logic [7:0] OFS_DISPLAY  = 8'h34;
	localparam logic [7:0] OFS_CORR     = 8'h38;
	localparam logic [7:0] OFS_FREQ     = 8'h3C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;

	////////////////////////////////////////////////////////////////////////////
	// Ranges and reset values
	localparam logic [14:0] PPR_MIN      = 15'h0001;
	localparam logic [14:0] PPR_MAX      = 15'h4E20;
	localparam logic [14:0] PPR_RST      = 15'h0258;
	localparam logic [3:0]  POLE_MIN     = 4'h2;
	localparam logic [3:0]  POLE_MAX     = 4'hA;
	localparam logic [3:0]  POLE_RST     = 4'h4;
	localparam logic [9:0]  KP_MAX       = 10'h3E8;
	localparam logic [9:0]  KP_RST       = 10'h064;
	localparam logic [9:0]  KI_MAX       = 10'h3E8;
	localparam logic [9:0]  KI_RST       = 10'h00A;
	localparam logic [13:0] LIMIT_MAX    = 14'h2710;
	localparam logic [13:0] LIMIT_RST    = 14'h03E8;
	localparam logic [13:0] INTERVAL_MAX = 14'h270F;
	localparam logic [13:0] DISP_INT_RST = 14'h01F4;
	localparam logic [13:0] FILT_TC_RST  = 14'h0010;
	localparam logic [6:0]  FTIME_MAX    = 7'h64;
	localparam logic [6:0]  FTIME_RST    = 7'h0A;
	localparam logic [4:0]  DISP_SEL_SPD = 5'h0E;
	localparam int unsigned GAIN_DIV     = 100;
	localparam int unsigned FILT_FRAC    = 8;
	// Frequency in 0.01 Hz = rpm * poles * 100 / 120
	localparam int unsigned HZ_NUM       = 5;
	localparam int unsigned HZ_DEN       = 6;

	// Interrupt status bits
	localparam int unsigned IRQ_FAULT    = 0;
	localparam int unsigned IRQ_DISP     = 1;
	localparam int unsigned IRQ_BITS     = 2;

	////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [1:0] {MODE_OFF, MODE_SINGLE, MODE_FWD, MODE_REV} esf_mode_type;
	typedef enum logic [1:0] {REACT_RAMP, REACT_COAST, REACT_RUN, REACT_BAD} esf_react_type;

endpackage

// file: core/esf_div_if.sv
// Purpose: Request and answer bundle between the speed logic and its divider
// Assumes: One clock, start is a one-cycle pulse while the divider is idle
// Notes:   done pulses once with quotient valid
`timescale 1ns/1ps
interface esf_div_if #(parameter int W = 32);
	logic         start;
	logic [W-1:0] dividend;
	logic [W-1:0] divisor;
	logic [W-1:0] quotient;
	logic         done;
	modport req (output start, dividend, divisor, input quotient, done);
	modport div (input start, dividend, divisor, output quotient, done);
endinterface

// file: core/esf_divider.sv
// Purpose: Sequential unsigned restoring divider
// Assumes: Divisor zero yields an all-ones quotient
// Notes:   W+1 cycles from start to done
`timescale 1ns/1ps
module esf_divider
	import esf_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic SYS_CLK,
	input  wire logic ARST_N,
	esf_div_if.div    dv
);

	logic [W-1:0]         rem;
	logic [W-1:0]         quo;
	logic [W-1:0]         dsr;
	logic [$clog2(W+1):0] cnt;
	logic                 busy;
	logic [W:0]           trial;

	// One shift-subtract step
	assign trial = {rem, quo[W-1]} - {1'b0, dsr};

	////////////////////////////////////////////////////////////////////////////
	// Iteration
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rem         <= '0;
			quo         <= '0;
			dsr         <= '0;
			cnt         <= '0;
			busy        <= 1'b0;
			dv.done     <= 1'b0;
			dv.quotient <= '0;
		end else begin
			dv.done <= 1'b0;
			if (dv.start && !busy) begin
				rem  <= '0;
				quo  <= dv.dividend;
				dsr  <= dv.divisor;
				cnt  <= ($clog2(W+1)+1)'(W);
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[W]) begin
					rem <= trial[W-1:0];
					quo <= {quo[W-2:0], 1'b1};
				end else begin
					rem <= {rem[W-2:0], quo[W-1]};
					quo <= {quo[W-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == 1) begin
					busy        <= 1'b0;
					dv.done     <= 1'b1;
					dv.quotient <= (trial[W]) ? {quo[W-2:0], 1'b0} : {quo[W-2:0], 1'b1};
				end
			end
		end
	end

endmodule

// file: core/esf_speed_feedback.sv
// Purpose: Encoder speed feedback, filter, display, PI correction and fault watch
// Assumes: Encoder and fault inputs synchronous to SYS_CLK; APB slave, no wait states
// Notes:   All slow work runs on a 2 ms tick from a divider
`timescale 1ns/1ps
module esf_speed_feedback
	import esf_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        ENC_A,
	input  wire logic        ENC_B,
	input  wire logic        RUN_ACTIVE,
	input  wire logic        ANALOG_FB_ABNORMAL,
	output logic      [15:0] FREQ_CORR,
	output logic      [15:0] DISPLAY_VALUE,
	output logic             DISPLAY_VALID,
	output logic             FAULT_WARN,
	output logic             STOP_RAMP,
	output logic             STOP_COAST,
	output logic             IRQ
);

	typedef enum {SEQ_IDLE, SEQ_SPEED, SEQ_FILTER} esf_seq_type;

	esf_mode_type         enc_mode;
	logic [14:0]          ppr;
	logic [3:0]           poles;
	logic [9:0]           kp;
	logic [9:0]           ki;
	logic [13:0]          limit;
	logic [13:0]          disp_int;
	logic [13:0]          filt_tc;
	logic [6:0]           ftime;
	esf_react_type        react;
	logic [4:0]           disp_sel;
	logic [15:0]          speed_ref;
	logic [IRQ_BITS-1:0]  irq_stat;
	logic [IRQ_BITS-1:0]  irq_mask;

	logic                 wr_en;
	logic                 rd_setup;
	logic                 mapped;
	logic [31:0]          wd;
	logic [31:0]          next_prdata;

	logic [$clog2(TICK_LEN+1)-1:0] tick_cnt;
	logic                 tick;
	logic [7:0]           gate_cnt;
	logic                 gate_end;
	logic                 a_prev;
	logic                 a_rise;
	logic [15:0]          pulse_cnt;
	logic [15:0]          gate_pulses;
	logic                 dir_err;
	logic                 gate_dir_err;

	esf_seq_type          seq;
	logic                 spd_pend;
	logic                 flt_pend;
	logic                 flt_neg;
	logic [15:0]          rpm_raw;
	logic [23:0]          rpm_q;
	logic [15:0]          rpm_filt;
	logic signed [24:0]   flt_diff;
	logic [31:0]          freq_hz;

	logic signed [16:0]   err;
	logic signed [27:0]   p_term;
	logic signed [27:0]   i_step;
	logic signed [27:0]   integ;
	logic signed [27:0]   next_integ;
	logic signed [27:0]   corr_sum;
	logic signed [27:0]   lim_s;

	logic [13:0]          disp_cnt;
	logic [13:0]          fault_cnt;
	logic                 enc_abn;
	logic                 abnormal;
	logic                 fault;
	logic                 fault_q;

	esf_div_if #(.W(32)) dv ();

	esf_divider #(.W(32)) u_div (
		.SYS_CLK (SYS_CLK),
		.ARST_N  (ARST_N),
		.dv      (dv)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB slave: no wait states, error on unmapped address
	assign wr_en    = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign wd       = PWDATA;
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL && PENABLE && !mapped;
	assign mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_IRQ_MASK);

	// Settings, out-of-range writes ignored
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			enc_mode  <= MODE_OFF;
			ppr       <= PPR_RST;
			poles     <= POLE_RST;
			kp        <= KP_RST;
			ki        <= KI_RST;
			limit     <= LIMIT_RST;
			disp_int  <= DISP_INT_RST;
			filt_tc   <= FILT_TC_RST;
			ftime     <= FTIME_RST;
			react     <= REACT_COAST;
			disp_sel  <= '0;
			speed_ref <= '0;
			irq_mask  <= '0;
		end else if (wr_en) begin
			unique case (PADDR)
				OFS_MODE: enc_mode <= esf_mode_type'(wd[1:0]);
				OFS_PPR: if (wd[14:0] >= PPR_MIN && wd[14:0] <= PPR_MAX && wd[31:15] == '0)
					ppr <= wd[14:0];
				OFS_POLES: if (wd[3:0] >= POLE_MIN && wd[3:0] <= POLE_MAX && !wd[0]
					&& wd[31:4] == '0)
					poles <= wd[3:0];
				OFS_KP: if (wd[9:0] <= KP_MAX && wd[31:10] == '0)
					kp <= wd[9:0];
				OFS_KI: if (wd[9:0] <= KI_MAX && wd[31:10] == '0)
					ki <= wd[9:0];
				OFS_LIMIT: if (wd[13:0] <= LIMIT_MAX && wd[31:14] == '0)
					limit <= wd[13:0];
				OFS_DISP_INT: if (wd[13:0] <= INTERVAL_MAX && wd[31:14] == '0)
					disp_int <= wd[13:0];
				OFS_FILT_TC: if (wd[13:0] <= INTERVAL_MAX && wd[31:14] == '0)
					filt_tc <= wd[13:0];
				OFS_FTIME: if (wd[6:0] <= FTIME_MAX && wd[31:7] == '0)
					ftime <= wd[6:0];
				OFS_REACT: if (wd[1:0] != REACT_BAD && wd[31:2] == '0)
					react <= esf_react_type'(wd[1:0]);
				OFS_DISP_SEL:  disp_sel  <= wd[4:0];
				OFS_SPEED_REF: speed_ref <= wd[15:0];
				OFS_IRQ_MASK:  irq_mask  <= wd[IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end

	// Read mux, sampled in the setup cycle
	always_comb begin
		next_prdata = '0;
		unique case (PADDR)
			OFS_MODE:      next_prdata = {30'h0, enc_mode};
			OFS_PPR:       next_prdata = {17'h0, ppr};
			OFS_POLES:     next_prdata = {28'h0, poles};
			OFS_KP:        next_prdata = {22'h0, kp};
			OFS_KI:        next_prdata = {22'h0, ki};
			OFS_LIMIT:     next_prdata = {18'h0, limit};
			OFS_DISP_INT:  next_prdata = {18'h0, disp_int};
			OFS_FILT_TC:   next_prdata = {18'h0, filt_tc};
			OFS_FTIME:     next_prdata = {25'h0, ftime};
			OFS_REACT:     next_prdata = {30'h0, react};
			OFS_DISP_SEL:  next_prdata = {27'h0, disp_sel};
			OFS_SPEED_REF: next_prdata = {16'h0, speed_ref};
			OFS_RPM:       next_prdata = {16'h0, rpm_filt};
			OFS_DISPLAY:   next_prdata = {15'h0, DISPLAY_VALID, DISPLAY_VALUE};
			OFS_CORR:      next_prdata = {{16{FREQ_CORR[15]}}, FREQ_CORR};
			OFS_FREQ:      next_prdata = freq_hz;
			OFS_IRQ_STAT:  next_prdata = {30'h0, irq_stat};
			OFS_IRQ_MASK:  next_prdata = {30'h0, irq_mask};
			default:       next_prdata = '0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			PRDATA <= '0;
		else if (rd_setup)
			PRDATA <= next_prdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// 2 ms tick and 100 ms gate
	assign tick     = (tick_cnt == ($clog2(TICK_LEN+1))'(TICK_LEN - 1));
	assign gate_end = tick && (gate_cnt == 8'(GATE_TICKS - 1));

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_cnt <= '0;
			gate_cnt <= '0;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (gate_end)
				gate_cnt <= '0;
			else if (tick)
				gate_cnt <= gate_cnt + 1'b1;
		end
	end

	// Pulse capture by mode; B level at A rise tells direction
	assign a_rise = ENC_A && !a_prev && (enc_mode != MODE_OFF);

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			a_prev       <= 1'b0;
			pulse_cnt    <= '0;
			gate_pulses  <= '0;
			dir_err      <= 1'b0;
			gate_dir_err <= 1'b0;
		end else begin
			a_prev <= ENC_A;
			if (gate_end) begin
				gate_pulses  <= pulse_cnt;
				gate_dir_err <= dir_err;
				pulse_cnt    <= '0;
				dir_err      <= 1'b0;
			end else if (a_rise) begin
				if (pulse_cnt != 16'hFFFF)
					pulse_cnt <= pulse_cnt + 1'b1;
				if ((enc_mode == MODE_FWD && ENC_B) || (enc_mode == MODE_REV && !ENC_B))
					dir_err <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Divider sequencer: speed conversion and filter step
	assign flt_diff = $signed({1'b0, rpm_raw, FILT_FRAC'(0)}) - $signed({1'b0, rpm_q});

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			seq         <= SEQ_IDLE;
			spd_pend    <= 1'b0;
			flt_pend    <= 1'b0;
			flt_neg     <= 1'b0;
			dv.start    <= 1'b0;
			dv.dividend <= '0;
			dv.divisor  <= '0;
			rpm_raw     <= '0;
			rpm_q       <= '0;
		end else begin
			dv.start <= 1'b0;
			spd_pend <= gate_end || (spd_pend && !(seq == SEQ_IDLE));
			flt_pend <= tick || (flt_pend && !(seq == SEQ_IDLE && !spd_pend));
			unique case (seq)
				SEQ_IDLE: begin
					if (spd_pend) begin
						dv.start    <= 1'b1;
						dv.dividend <= 32'(gate_pulses) * 32'(RPM_SCALE);
						dv.divisor  <= 32'(ppr);
						seq         <= SEQ_SPEED;
					end else if (flt_pend) begin
						dv.start    <= 1'b1;
						flt_neg     <= flt_diff[24];
						dv.dividend <= 32'(flt_diff[24] ? -flt_diff : flt_diff);
						dv.divisor  <= 32'(filt_tc) + 32'd1;
						seq         <= SEQ_FILTER;
					end
				end
				SEQ_SPEED: if (dv.done) begin
					rpm_raw <= (dv.quotient[31:16] != '0) ? 16'hFFFF : dv.quotient[15:0];
					seq     <= SEQ_IDLE;
				end
				SEQ_FILTER: if (dv.done) begin
					rpm_q <= flt_neg ? rpm_q - dv.quotient[23:0] : rpm_q + dv.quotient[23:0];
					seq   <= SEQ_IDLE;
				end
			endcase
		end
	end

	assign rpm_filt = rpm_q[23:FILT_FRAC];
	assign freq_hz  = (32'(rpm_filt) * 32'(poles) * 32'(HZ_NUM)) / 32'(HZ_DEN);

	////////////////////////////////////////////////////////////////////////////
	// PI regulator on each tick
	assign err      = $signed({1'b0, speed_ref}) - $signed({1'b0, rpm_filt});
	assign lim_s    = $signed({14'h0, limit});
	assign p_term   = (28'(err) * $signed({18'h0, kp})) / $signed(28'(GAIN_DIV));
	assign i_step   = (28'(err) * $signed({18'h0, ki})) / $signed(28'(GAIN_DIV));
	assign corr_sum = p_term + integ;

	// Integrator clamped to the limit against windup
	always_comb begin
		next_integ = integ + i_step;
		if (next_integ > lim_s)
			next_integ = lim_s;
		else if (next_integ < -lim_s)
			next_integ = -lim_s;
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			integ     <= '0;
			FREQ_CORR <= '0;
		end else if (enc_mode == MODE_OFF || !RUN_ACTIVE) begin
			integ     <= '0;
			FREQ_CORR <= '0;
		end else if (tick) begin
			integ <= next_integ;
			if (corr_sum > lim_s)
				FREQ_CORR <= 16'(lim_s);
			else if (corr_sum < -lim_s)
				FREQ_CORR <= 16'(-lim_s);
			else
				FREQ_CORR <= 16'(corr_sum);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Display refresh
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			disp_cnt      <= '0;
			DISPLAY_VALUE <= '0;
			DISPLAY_VALID <= 1'b0;
		end else if (tick) begin
			if (disp_cnt >= disp_int) begin
				disp_cnt      <= '0;
				DISPLAY_VALID <= (disp_sel == DISP_SEL_SPD);
				DISPLAY_VALUE <= (disp_sel == DISP_SEL_SPD) ? rpm_filt : '0;
			end else begin
				disp_cnt <= disp_cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Feedback fault supervision
	assign enc_abn  = RUN_ACTIVE && (enc_mode != MODE_OFF) && ((rpm_raw == '0) || gate_dir_err);
	assign abnormal = ANALOG_FB_ABNORMAL || enc_abn;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fault_cnt <= '0;
			fault     <= 1'b0;
		end else if (ftime == '0) begin
			fault_cnt <= '0;
			fault     <= 1'b0;
		end else begin
			if (!abnormal)
				fault_cnt <= '0;
			else if (tick && fault_cnt != 14'h3FFF)
				fault_cnt <= fault_cnt + 1'b1;
			if (abnormal && fault_cnt >= 14'(ftime) * 14'(FAULT_UNIT_TICKS))
				fault <= 1'b1;
			else if (!abnormal && wr_en && PADDR == OFS_IRQ_STAT && wd[IRQ_FAULT])
				fault <= 1'b0;
		end
	end

	// Reaction outputs
	assign FAULT_WARN = fault;
	assign STOP_RAMP  = fault && (react == REACT_RAMP);
	assign STOP_COAST = fault && (react == REACT_COAST);

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over write-one-to-clear
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_stat <= '0;
		end else begin
			for (int i = 0; i < IRQ_BITS; i++) begin
				if (wr_en && PADDR == OFS_IRQ_STAT && wd[i])
					irq_stat[i] <= 1'b0;
			end
			if (fault && !fault_q)
				irq_stat[IRQ_FAULT] <= 1'b1;
			if (tick && disp_cnt >= disp_int)
				irq_stat[IRQ_DISP] <= 1'b1;
		end
	end

	// Fault level delayed one cycle for rise detection
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			fault_q <= 1'b0;
		else
			fault_q <= fault;
	end

	assign IRQ = |(irq_stat & irq_mask);

endmodule

// file: tb/esf_monitor.sv
// Purpose: Port-level checks of the speed feedback block
// Assumes: Bound to the top module, one clock domain
// Notes:   TICK_LEN is handed on from the bound instance
`timescale 1ns/1ps
module esf_monitor
	import esf_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic        SYS_CLK,
	input wire logic        ARST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        RUN_ACTIVE,
	input wire logic [15:0] FREQ_CORR,
	input wire logic        FAULT_WARN,
	input wire logic        STOP_RAMP,
	input wire logic        STOP_COAST
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	int unsigned idle_cnt;
	// Cycles spent with the drive stopped
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			idle_cnt <= 0;
		else if (RUN_ACTIVE)
			idle_cnt <= 0;
		else if (idle_cnt < 1000)
			idle_cnt <= idle_cnt + 1;
	end
	sequence s_setup;
		PSEL && !PENABLE ##1 PSEL && PENABLE;
	endsequence
	sequence s_fault_on;
		FAULT_WARN && !(PSEL && PWRITE);
	endsequence
	property p_ready;
		PSEL && PENABLE |-> PREADY;
	endproperty
	property p_unmapped;
		PSEL && PENABLE && (PADDR > 8'h44 || PADDR[1:0] != 2'h0) |-> PSLVERR;
	endproperty
	property p_mapped;
		PSEL && PENABLE && PADDR <= 8'h44 && PADDR[1:0] == 2'h0 |-> !PSLVERR;
	endproperty
	property p_rdata_hold;
		s_setup |=> $stable(PRDATA);
	endproperty
	property p_stop_excl;
		STOP_RAMP |-> !STOP_COAST;
	endproperty
	property p_stop_cause;
		STOP_RAMP || STOP_COAST |-> FAULT_WARN;
	endproperty
	property p_fault_hold;
		s_fault_on |=> FAULT_WARN;
	endproperty
	property p_corr_bound;
		$signed(FREQ_CORR) <= 16'sh2710 && $signed(FREQ_CORR) >= -16'sh2710;
	endproperty
	property p_corr_idle;
		idle_cnt > TICK_LEN + 1 |-> FREQ_CORR == 16'h0000;
	endproperty
	a_ready: assert property (p_ready) else $error("slave not ready");
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
	a_mapped: assert property (p_mapped) else $error("error on mapped access");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_stop_excl: assert property (p_stop_excl) else $error("two stop kinds");
	a_stop_cause: assert property (p_stop_cause) else $error("stop without fault");
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
	a_corr_bound: assert property (p_corr_bound) else $error("correction too big");
	a_corr_idle: assert property (p_corr_idle) else $error("correction when idle");
endmodule

// file: tb/esf_encoder_model.sv
// Purpose: Behavioural shaft pulse encoder
// Assumes: Period of at least four clocks
// Notes:   Lines stand low while the shaft is stopped
`timescale 1ns/1ps
module esf_encoder_model (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       rev,
	input  wire logic [7:0] period,
	output logic            phase_a,
	output logic            phase_b
);
	int cnt;
	initial {phase_a, phase_b} = 2'b00;
	// Quadrature phases, B low at A rise when turning forward
	always @(posedge clk) begin
		if (!run) begin
			cnt     <= 0;
			phase_a <= 1'b0;
			phase_b <= 1'b0;
		end else begin
			cnt     <= (cnt + 1) % period;
			phase_a <= cnt < period / 2;
			phase_b <= ((cnt >= period / 4) && (cnt < 3 * period / 4)) ^ rev;
		end
	end
endmodule

// file: tb/esf_speed_feedback_tb.sv
// Purpose: Self-checking bench of the speed feedback block
// Assumes: Short tick of 20 clocks
// Notes:   Register model kept in an associative array
`timescale 1ns/1ps
module esf_speed_feedback_tb
	import esf_pkg::*;
;
	localparam int TL = 20;
	logic        clk, arst_n, psel, penable, pwrite, run, fb_bad, enc_on, enc_rev, ea, eb;
	logic        pready, pslverr, disp_ok, fault, s_ramp, s_coast, irq, rerr;
	logic [7:0]  paddr, enc_per;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] corr, disp;
	int          mismatches, comparisons, rpm, p, q, k, model [int];
	logic [7:0]  set_a [9] = '{OFS_PPR, OFS_POLES, OFS_KP, OFS_KI, OFS_LIMIT, OFS_DISP_INT,
		OFS_FILT_TC, OFS_FTIME, OFS_REACT};
	int          set_m [9] = '{PPR_MAX, POLE_MAX, KP_MAX, KI_MAX, LIMIT_MAX, INTERVAL_MAX,
		INTERVAL_MAX, FTIME_MAX, 2};
	int          pers [4] = '{20, 25, 40, 50};
	int          pprs [3] = '{10, 20, 50};
	always #12.5 clk = ~clk;
	esf_speed_feedback #(.TICK_LEN(TL)) DUT (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .ENC_A(ea), .ENC_B(eb), .RUN_ACTIVE(run),
		.ANALOG_FB_ABNORMAL(fb_bad), .FREQ_CORR(corr), .DISPLAY_VALUE(disp),
		.DISPLAY_VALID(disp_ok), .FAULT_WARN(fault), .STOP_RAMP(s_ramp),
		.STOP_COAST(s_coast), .IRQ(irq));
	esf_encoder_model u_enc (.clk(clk), .run(enc_on), .rev(enc_rev), .period(enc_per),
		.phase_a(ea), .phase_b(eb));
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("Mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk_w(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t word %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_b(logic got, logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	function automatic bit ok(int a, int v);
		case (a)
			OFS_PPR:   return v >= PPR_MIN && v <= PPR_MAX;
			OFS_POLES: return v >= POLE_MIN && v <= POLE_MAX && v % 2 == 0;
			OFS_MODE, OFS_DISP_SEL, OFS_SPEED_REF, OFS_IRQ_MASK: return 1'b1;
			OFS_IRQ_STAT, OFS_RPM, OFS_DISPLAY, OFS_CORR, OFS_FREQ: return 1'b0;
			default: begin
				foreach (set_a[i])
					if (set_a[i] == a)
						return v <= set_m[i];
				return 1'b0;
			end
		endcase
	endfunction
	// One APB transfer, entered just after an edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(int a, int v);
		apb(1'b1, a[7:0], v);
		if (ok(a, v))
			model[a] = v;
	endtask
	task automatic rd(int a);
		apb(1'b0, a[7:0], 32'h0);
		chk_w(rdat, model[a]);
		chk_b(rerr, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{clk, arst_n, psel, penable, pwrite, run, fb_bad, enc_on, enc_rev} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		enc_per = 8'h14;
		for (int a = 0; a <= 68; a += 4)
			model[a] = 0;
		model[OFS_PPR] = PPR_RST;
		model[OFS_POLES] = POLE_RST;
		model[OFS_KP] = KP_RST;
		model[OFS_KI] = KI_RST;
		model[OFS_LIMIT] = LIMIT_RST;
		model[OFS_DISP_INT] = DISP_INT_RST;
		model[OFS_FILT_TC] = FILT_TC_RST;
		model[OFS_FTIME] = FTIME_RST;
		model[OFS_REACT] = REACT_COAST;
		void'($urandom(69));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a <= 68; a += 4)
			rd(a);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_MODE, m);
			rd(OFS_MODE);
		end
		// Out-of-range then random settings
		foreach (set_a[i]) begin
			wr(set_a[i], set_m[i] + 1);
			rd(set_a[i]);
			wr(set_a[i], $urandom_range(set_m[i]));
			rd(set_a[i]);
		end
		apb(1'b0, 8'h48, 32'h0);
		chk_b(rerr, 1'b1);
		apb(1'b1, 8'h06, 32'h0);
		chk_b(rerr, 1'b1);
		// Speed measurement and display
		wr(OFS_FTIME, 0);
		wr(OFS_FILT_TC, 0);
		wr(OFS_DISP_SEL, DISP_SEL_SPD);
		wr(OFS_DISP_INT, 0);
		enc_on <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			p = pers[$urandom_range(3)];
			q = pprs[$urandom_range(2)];
			k = 2 * (1 + $urandom_range(4));
			enc_per <= p[7:0];
			wr(OFS_MODE, r + 1);
			wr(OFS_PPR, q);
			wr(OFS_POLES, k);
			repeat (3500) @(posedge clk);
			rpm = GATE_TICKS * TL / p * 600 / q;
			model[OFS_RPM] = rpm;
			model[OFS_FREQ] = rpm * k * 100 / 120;
			rd(OFS_RPM);
			rd(OFS_FREQ);
			chk_w({16'h0000, disp}, rpm);
			chk_b(disp_ok, 1'b1);
		end
		wr(OFS_IRQ_MASK, 2);
		#1 chk_b(irq, 1'b1);
		wr(OFS_IRQ_MASK, 0);
		#1 chk_b(irq, 1'b0);
		// Regulator saturates both ways, then idles
		wr(OFS_LIMIT, 500);
		wr(OFS_KP, 1000);
		wr(OFS_KI, 1000);
		run <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			wr(OFS_SPEED_REF, s ? 0 : rpm + 1000);
			repeat (40 * TL) @(posedge clk);
			model[OFS_CORR] = s ? -500 : 500;
			rd(OFS_CORR);
			chk_w({{16{corr[15]}}, corr}, model[OFS_CORR]);
		end
		run <= 1'b0;
		repeat (3 * TL) @(posedge clk);
		chk_w({16'h0000, corr}, 0);
		// Fault from analog or encoder, each reaction
		wr(OFS_FTIME, 1);
		wr(OFS_IRQ_MASK, 1);
		run <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			wr(OFS_REACT, r);
			wr(OFS_MODE, r == 1 ? MODE_FWD : MODE_OFF);
			enc_rev <= r == 1;
			fb_bad <= r != 1;
			repeat (700) @(posedge clk);
			chk_b(fault, 1'b0);
			repeat (3000) @(posedge clk);
			chk_b(fault, 1'b1);
			chk_b(s_ramp, r == 0);
			chk_b(s_coast, r == 1);
			chk_b(irq, 1'b1);
			fb_bad <= 1'b0;
			wr(OFS_MODE, MODE_OFF);
			wr(OFS_IRQ_STAT, 1);
			#1 chk_b(fault, 1'b0);
			chk_b(irq, 1'b0);
		end
		wr(OFS_FTIME, 0);
		fb_bad <= 1'b1;
		repeat (3000) @(posedge clk);
		chk_b(fault, 1'b0);
		finish_test();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		finish_test();
	end
endmodule
bind esf_speed_feedback esf_monitor #(.TICK_LEN(TICK_LEN)) u_mon (.SYS_CLK(SYS_CLK),
	.ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_ACTIVE(RUN_ACTIVE),
	.FREQ_CORR(FREQ_CORR), .FAULT_WARN(FAULT_WARN), .STOP_RAMP(STOP_RAMP),
	.STOP_COAST(STOP_COAST));
